// ---- core/pcs_pkg.sv ----
/*
  constants shared by the configuration/status register bank:
  management frame fields, register addresses, field positions,
  reset values and sleep timeouts.
  assumes a 100 MHz system clock.
*/
package pcs_pkg;
  // ----------------------------------------------------------
  // management frame
  // ----------------------------------------------------------
  localparam int PREAMBLE_ONES = 32;  // ones before a start
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam int HDR_BITS = 12;  // opcode, phy address, reg address
  localparam int DATA_BITS = 16;

  // ----------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------
  localparam logic [4:0] REG_CFG = 5'h10;  // extended configuration
  localparam logic [4:0] REG_STAT2 = 5'h11;  // live status two

  // ----------------------------------------------------------
  // configuration field positions
  // ----------------------------------------------------------
  localparam int CFG_LOOP_SUP = 8;
  localparam int CFG_CRS_EXT = 7;
  localparam int CFG_SLEEP_EN = 6;
  localparam int CFG_PRE_PASS = 5;
  localparam int CFG_TIMER_HI = 4;
  localparam int CFG_TIMER_LO = 3;
  localparam int CFG_FEFI_EN = 2;
  localparam int CFG_ALT_NP = 1;
  localparam int CFG_FIBER = 0;

  // ----------------------------------------------------------
  // status field positions
  // ----------------------------------------------------------
  localparam int ST_TX_MODE = 14;
  localparam int ST_XMIT = 13;
  localparam int ST_RECV = 12;
  localparam int ST_COL = 11;
  localparam int ST_LINK = 10;

  // ----------------------------------------------------------
  // reset values
  // ----------------------------------------------------------
  localparam logic RST_LOOP_SUP = 1'h0;
  localparam logic RST_CRS_EXT = 1'h0;
  localparam logic RST_PRE_PASS = 1'h0;
  localparam logic [1:0] RST_TIMER = 2'h0;
  localparam logic RST_FEFI_EN = 1'h1;
  localparam logic RST_ALT_NP = 1'h0;
  localparam logic [15:0] RST_STATUS = 16'h0000;

  // ----------------------------------------------------------
  // sleep timeouts
  // ----------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SLEEP_T0_MS = 3040;
  localparam int SLEEP_T1_MS = 2000;
  localparam int SLEEP_T2_MS = 1040;
  localparam int SLEEP_T0_CYC = SLEEP_T0_MS * 1000 * CLK_MHZ;
  localparam int SLEEP_T1_CYC = SLEEP_T1_MS * 1000 * CLK_MHZ;
  localparam int SLEEP_T2_CYC = SLEEP_T2_MS * 1000 * CLK_MHZ;
  localparam logic [1:0] TIMER_UNUSED = 2'h3;
endpackage : pcs_pkg

// ---- core/pcs_sleep_if.sv ----
/*
  carrier between the register bank and its sleep timer.
  assumes both ends share clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
interface pcs_sleep_if;
  logic enable;  // sleep permitted
  logic [1:0] sel;  // timeout code
  logic activity;  // line energy or link present
  logic asleep;  // timeout reached
  modport ctrl (output enable, output sel, output activity, input asleep);
  modport timer (input enable, input sel, input activity, output asleep);
endinterface : pcs_sleep_if
`default_nettype wire

// ---- core/pcs_sleep_timer.sv ----
/*
  idle timer that decides when low-power sleep is entered.
  assumes enable, sel and activity are synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module pcs_sleep_timer #(
  parameter int T0_CYC = pcs_pkg::SLEEP_T0_CYC,
  parameter int T1_CYC = pcs_pkg::SLEEP_T1_CYC,
  parameter int T2_CYC = pcs_pkg::SLEEP_T2_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  pcs_sleep_if.timer slp
);
  // ----------------------------------------------------------
  // idle counter
  // ----------------------------------------------------------
  logic [31:0] idle_cnt;  // cycles without activity
  logic [31:0] limit;  // selected timeout

  // timeout per code; the unused code never sleeps
  always_comb
  begin
    unique case (slp.sel)
      2'h0: limit = 32'(T0_CYC);
      2'h1: limit = 32'(T1_CYC);
      2'h2: limit = 32'(T2_CYC);
      2'h3: limit = 32'h0000_0000;
    endcase
  end

  // count idle time, restart on any activity
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      idle_cnt <= 32'h0000_0000;
      slp.asleep <= 1'b0;
    end
    else if (!slp.enable || slp.activity || slp.sel == pcs_pkg::TIMER_UNUSED)
    begin
      idle_cnt <= 32'h0000_0000;
      slp.asleep <= 1'b0;
    end
    else if (idle_cnt >= limit - 32'h0000_0001)
      slp.asleep <= 1'b1;  // saturate, stay asleep
    else
      idle_cnt <= idle_cnt + 32'h0000_0001;
  end
endmodule : pcs_sleep_timer
`default_nettype wire

// ---- core/pcs_regs.sv ----
/*
  configuration and live status registers of a 10/100 transceiver,
  reached over the serial management port, plus the receive-side
  carrier and preamble shaping that the configuration steers.
  assumes mdc and mdio_i are synchronous to clk_sys and mdc is
  well below half the clock rate.
*/
// Function
// - alternate next-page bit gates page capability
// - media select, reset value from strap
// - suppress 10M half-duplex loopback when set
// - 10M carrier held until receive valid drops
// - no preamble: valid rises with delimiter
// - preamble pass: valid with carrier, preamble out
// - 100M always delivers preamble
// - sleep timeout codes 3.04/2.00/1.04 s
// - far-end fault send enable, reset one
// - status shows 100BASE-TX mode
// - status shows transmit activity
// - status shows receive activity
// - status shows collision
// - status shows link up
`timescale 1ns/1ps
`default_nettype none
module pcs_regs #(
  parameter int T0_CYC = pcs_pkg::SLEEP_T0_CYC,
  parameter int T1_CYC = pcs_pkg::SLEEP_T1_CYC,
  parameter int T2_CYC = pcs_pkg::SLEEP_T2_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  input wire logic strap_media,
  input wire logic strap_sleep,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic link_up,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic col_active,
  input wire logic crs_line,
  input wire logic line_rx_valid,
  input wire logic line_sfd,
  input wire logic [3:0] line_rxd,
  input wire logic np_ability,
  output logic next_page_cap,
  output logic fiber_mode,
  output logic ten_meg_loopback_suppress_en,
  output logic fefi_tx_en,
  output logic crs,
  output logic rx_dv,
  output logic [3:0] rxd,
  output logic sleep_mode
);
  // ----------------------------------------------------------
  // configuration fields and status
  // ----------------------------------------------------------
  logic alt_next_page_enable;
  logic fiber_select;
  logic ten_meg_loopback_suppress;
  logic carrier_extend_select;
  logic sleep_enable;
  logic preamble_pass;
  logic [1:0] sleep_timer_sel;
  logic fault_code_enable;
  logic strap_done;  // straps captured once after reset
  logic [15:0] status;  // live status two image
  logic [15:0] cfg_word;
  logic [15:0] rd_word;

  // ----------------------------------------------------------
  // management port engine
  // ----------------------------------------------------------
  typedef enum logic [2:0] {MD_PRE, MD_ST, MD_HDR, MD_TA, MD_DATA} pcs_md_st_t;
  pcs_md_st_t md_st;
  logic mdc_q;  // previous mdc level for edge find
  logic mdc_rise;
  logic [5:0] md_cnt;  // bit counter in the current field
  logic [11:0] hdr;  // opcode, phy address, register address
  logic [15:0] shift;  // data in or out
  logic is_rd;
  logic cfg_wr;
  logic [11:0] next_hdr;

  assign mdc_rise = mdc & ~mdc_q;
  assign next_hdr = {hdr[10:0], mdio_i};
  // a write lands on the edge that samples the last data bit
  assign cfg_wr = mdc_rise && md_st == MD_DATA && !is_rd
    && md_cnt == 6'(pcs_pkg::DATA_BITS - 1) && hdr[4:0] == pcs_pkg::REG_CFG;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      mdc_q <= 1'b0;
    else
      mdc_q <= mdc;
  end

  // frame walk: preamble, start, header, turnaround, data
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      md_st <= MD_PRE;
      md_cnt <= 6'h00;
      hdr <= 12'h000;
      shift <= 16'h0000;
      is_rd <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
    end
    else if (mdc_rise)
    begin
      unique case (md_st)
        MD_PRE:
        begin
          // ones saturate; a zero after enough ones is the start
          if (mdio_i)
            md_cnt <= (md_cnt == 6'(pcs_pkg::PREAMBLE_ONES)) ? md_cnt : md_cnt + 6'h01;
          else if (md_cnt == 6'(pcs_pkg::PREAMBLE_ONES))
            md_st <= MD_ST;
          else
            md_cnt <= 6'h00;
        end
        MD_ST:
        begin
          md_cnt <= 6'h00;
          md_st <= mdio_i ? MD_HDR : MD_PRE;
        end
        MD_HDR:
        begin
          hdr <= next_hdr;
          md_cnt <= md_cnt + 6'h01;
          if (md_cnt == 6'(pcs_pkg::HDR_BITS - 1))
          begin
            md_cnt <= 6'h00;
            is_rd <= next_hdr[11:10] == pcs_pkg::OP_READ;
            // other addresses and bad opcodes fall back to hunting
            if (next_hdr[9:5] == phy_addr
                && (next_hdr[11:10] == pcs_pkg::OP_READ
                || next_hdr[11:10] == pcs_pkg::OP_WRITE))
              md_st <= MD_TA;
            else
              md_st <= MD_PRE;
          end
        end
        MD_TA:
        begin
          md_cnt <= md_cnt + 6'h01;
          if (md_cnt == 6'h00)
          begin
            // second turnaround bit is ours to drive low on a read
            mdio_oe <= is_rd;
            mdio_o <= 1'b0;
          end
          else
          begin
            md_cnt <= 6'h00;
            md_st <= MD_DATA;
            shift <= is_rd ? rd_word : 16'h0000;
            mdio_o <= is_rd & rd_word[15];
          end
        end
        MD_DATA:
        begin
          md_cnt <= md_cnt + 6'h01;
          shift <= {shift[14:0], mdio_i};
          mdio_o <= is_rd & shift[14];
          if (md_cnt == 6'(pcs_pkg::DATA_BITS - 1))
          begin
            md_cnt <= 6'h00;
            mdio_oe <= 1'b0;
            mdio_o <= 1'b0;
            md_st <= MD_PRE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------
  always_comb
  begin
    cfg_word = 16'h0000;
    cfg_word[pcs_pkg::CFG_LOOP_SUP] = ten_meg_loopback_suppress;
    cfg_word[pcs_pkg::CFG_CRS_EXT] = carrier_extend_select;
    cfg_word[pcs_pkg::CFG_SLEEP_EN] = sleep_enable;
    cfg_word[pcs_pkg::CFG_PRE_PASS] = preamble_pass;
    cfg_word[pcs_pkg::CFG_TIMER_HI:pcs_pkg::CFG_TIMER_LO] = sleep_timer_sel;
    cfg_word[pcs_pkg::CFG_FEFI_EN] = fault_code_enable;
    cfg_word[pcs_pkg::CFG_ALT_NP] = alt_next_page_enable;
    cfg_word[pcs_pkg::CFG_FIBER] = fiber_select;
  end

  // unmapped addresses read zero
  assign rd_word = (hdr[4:0] == pcs_pkg::REG_CFG) ? cfg_word
    : (hdr[4:0] == pcs_pkg::REG_STAT2) ? status : 16'h0000;

  // ----------------------------------------------------------
  // phy_extended_configuration
  // ----------------------------------------------------------
  // straps cannot be loaded under async reset, so they are taken
  // on the first edge after release; no frame can finish that soon
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_done <= 1'b0;
      fiber_select <= 1'b0;
      sleep_enable <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      fiber_select <= strap_media;
      sleep_enable <= strap_sleep;
    end
    else if (cfg_wr)
    begin
      fiber_select <= mdio_i;
      sleep_enable <= shift[pcs_pkg::CFG_SLEEP_EN - 1];
    end
  end

  // remaining fields; the data word is {shift[14:0], mdio_i}
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ten_meg_loopback_suppress <= pcs_pkg::RST_LOOP_SUP;
      carrier_extend_select <= pcs_pkg::RST_CRS_EXT;
      preamble_pass <= pcs_pkg::RST_PRE_PASS;
      sleep_timer_sel <= pcs_pkg::RST_TIMER;
      fault_code_enable <= pcs_pkg::RST_FEFI_EN;
      alt_next_page_enable <= pcs_pkg::RST_ALT_NP;
    end
    else if (cfg_wr)
    begin
      ten_meg_loopback_suppress <= shift[pcs_pkg::CFG_LOOP_SUP - 1];
      carrier_extend_select <= shift[pcs_pkg::CFG_CRS_EXT - 1];
      preamble_pass <= shift[pcs_pkg::CFG_PRE_PASS - 1];
      sleep_timer_sel <= shift[pcs_pkg::CFG_TIMER_HI - 1:pcs_pkg::CFG_TIMER_LO - 1];
      fault_code_enable <= shift[pcs_pkg::CFG_FEFI_EN - 1];
      alt_next_page_enable <= shift[pcs_pkg::CFG_ALT_NP - 1];
    end
  end

  // ----------------------------------------------------------
  // live status two
  // ----------------------------------------------------------
  // no write path, reserved bits stay zero
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      status <= pcs_pkg::RST_STATUS;
    else
    begin
      status <= 16'h0000;
      // fiber at 100 is not TX mode
      status[pcs_pkg::ST_TX_MODE] <= speed_100 & ~fiber_select;
      status[pcs_pkg::ST_XMIT] <= tx_active;
      status[pcs_pkg::ST_RECV] <= rx_active;
      status[pcs_pkg::ST_COL] <= col_active;
      status[pcs_pkg::ST_LINK] <= link_up;
    end
  end

  // ----------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      next_page_cap <= 1'b0;
      fiber_mode <= 1'b0;
      ten_meg_loopback_suppress_en <= 1'b0;
      fefi_tx_en <= 1'b0;
    end
    else
    begin
      next_page_cap <= alt_next_page_enable & np_ability;
      fiber_mode <= fiber_select;
      // loopback only in 10M half-duplex twisted pair
      ten_meg_loopback_suppress_en <= ~fiber_select & ~speed_100 & ~full_duplex
        & ~ten_meg_loopback_suppress;
      fefi_tx_en <= fault_code_enable;
    end
  end

  // ----------------------------------------------------------
  // receive shaping
  // ----------------------------------------------------------
  logic sfd_seen;  // delimiter already passed in this frame
  logic pass_pre;
  logic next_rx_dv;

  assign pass_pre = preamble_pass | speed_100;
  // without pass, valid waits for the delimiter
  // with pass, valid follows carrier from the first nibble
  assign next_rx_dv = line_rx_valid & (pass_pre | sfd_seen | line_sfd);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sfd_seen <= 1'b0;
      rx_dv <= 1'b0;
      rxd <= 4'h0;
      crs <= 1'b0;
    end
    else
    begin
      sfd_seen <= line_rx_valid & (sfd_seen | line_sfd);
      rx_dv <= next_rx_dv;
      rxd <= next_rx_dv ? line_rxd : 4'h0;
      // 10M carrier stretched while receive valid stands
      crs <= crs_line | (carrier_extend_select & ~speed_100 & next_rx_dv);
    end
  end

  // ----------------------------------------------------------
  // sleep
  // ----------------------------------------------------------
  pcs_sleep_if slp ();
  assign slp.enable = sleep_enable;
  // timeout code handed to the timer
  assign slp.sel = sleep_timer_sel;
  assign slp.activity = link_up | crs_line;

  pcs_sleep_timer #(
    .T0_CYC(T0_CYC),
    .T1_CYC(T1_CYC),
    .T2_CYC(T2_CYC)
  ) i_pcs_sleep_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .slp(slp.timer)
  );

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      sleep_mode <= 1'b0;
    else
      sleep_mode <= slp.asleep;
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_np_gate: assert property (!alt_next_page_enable |=> !next_page_cap)
    else $error("next page capability with gate off");
  chk_media_strap: assert property (
      $rose(strap_done) |-> fiber_select == $past(strap_media))
    else $error("media select missed strap");
  chk_loop_block: assert property (ten_meg_loopback_suppress |=> !ten_meg_loopback_suppress_en)
    else $error("loopback active while suppressed");
  chk_crs_extend: assert property (
      rx_dv && $past(carrier_extend_select) && !$past(speed_100) |-> crs)
    else $error("carrier dropped before receive valid");
  chk_sleep_strap: assert property (
      $rose(strap_done) |-> sleep_enable == $past(strap_sleep))
    else $error("sleep enable missed strap");
  chk_no_preamble: assert property (
      line_rx_valid && !line_sfd && !sfd_seen && !pass_pre |=> !rx_dv)
    else $error("preamble leaked with pass off");
  chk_pre_pass: assert property (
      line_rx_valid && preamble_pass |=> rx_dv && rxd == $past(line_rxd))
    else $error("preamble not passed");
  chk_fast_pre: assert property (line_rx_valid && speed_100 |=> rx_dv)
    else $error("100M preamble not delivered");
  chk_timer_unused: assert property (
      (sleep_timer_sel == pcs_pkg::TIMER_UNUSED) [*2] |=> !sleep_mode)
    else $error("sleep on unused timer code");
  chk_fefi_off: assert property ($fell(fault_code_enable) |=> !fefi_tx_en)
    else $error("fault send after disable");
  chk_tx_mode: assert property (
      speed_100 && !fiber_select |=> status[pcs_pkg::ST_TX_MODE])
    else $error("100BASE-TX status missing");
  chk_link_stat: assert property (!link_up |=> !status[pcs_pkg::ST_LINK])
    else $error("link status up while down");
  chk_stat_rsvd: assert property (status[15] == 1'b0 && status[9:0] == 10'h000)
    else $error("reserved status bit set");

  cov_read_frame: cover property (md_st == MD_DATA && is_rd ##1 md_st == MD_PRE);
  cov_cfg_write: cover property (cfg_wr);
  cov_sleep: cover property ($rose(sleep_mode));
  cov_pre_pass: cover property (rx_dv && preamble_pass && !speed_100);
endmodule : pcs_regs
`default_nettype wire

// ---- sim/pcs_mgmt_model.sv ----
/*
  station management model: makes mdc and sends management frames.
  assumes the bench resolves the mdio wire, with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module pcs_mgmt_model (
  input wire logic clk_sys,
  input wire logic mdio_wire,
  output logic mdc,
  output logic mdio_drv,
  output logic mdio_en
);
  // mdc stands low outside frames
  initial
  begin
    mdc = 1'b0;
    mdio_drv = 1'b0;
    mdio_en = 1'b0;
  end

  // ----------------------------------------------------------
  // one frame, eight clocks per mdc period
  // ----------------------------------------------------------
  // bits change while mdc is low; read data is taken just before each rise
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hffff_ffff, 2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--)
    begin
      @(posedge clk_sys);
      #1;
      mdc = 1'b0;
      // a read hands the wire over for turnaround and data
      mdio_en = !(op == pcs_pkg::OP_READ && i < 18);
      mdio_drv = bits[i];
      repeat (4) @(posedge clk_sys);
      #1;
      if (i < 16)
        rd[i] = mdio_wire;
      mdc = 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    #1;
    mdc = 1'b0;
    mdio_en = 1'b0;
  endtask : frame
endmodule : pcs_mgmt_model
`default_nettype wire

// ---- sim/test_pcs_regs.sv ----
/*
  self-checking bench of the configuration/status register bank.
  assumes pcs_pkg, the design and the management model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_pcs_regs;
  logic clk_sys, nrst, mdc, m_drv, m_en, mdio_o, mdio_oe;
  logic strap_media, strap_sleep, speed_100, full_duplex, link_up, tx_active;
  logic rx_active, col_active, crs_line, line_rx_valid, line_sfd, np_ability;
  logic [3:0] line_rxd, rxd;
  logic next_page_cap, fiber_mode, ten_meg_loopback_suppress_en, fefi_tx_en, crs, rx_dv, sleep_mode;
  int err_count = 0;
  int n_compared = 0;
  // pull-up when nobody drives the wire
  wire logic mdio_wire = mdio_oe ? mdio_o : (m_en ? m_drv : 1'b1);

  pcs_regs #(.T0_CYC(40), .T1_CYC(20), .T2_CYC(10)) i_pcs_regs (
    .clk_sys(clk_sys), .nrst(nrst), .mdc(mdc), .mdio_i(mdio_wire), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .phy_addr(5'h03), .strap_media(strap_media),
    .strap_sleep(strap_sleep), .speed_100(speed_100), .full_duplex(full_duplex),
    .link_up(link_up), .tx_active(tx_active), .rx_active(rx_active),
    .col_active(col_active), .crs_line(crs_line), .line_rx_valid(line_rx_valid),
    .line_sfd(line_sfd), .line_rxd(line_rxd), .np_ability(np_ability),
    .next_page_cap(next_page_cap), .fiber_mode(fiber_mode),
    .ten_meg_loopback_suppress_en(ten_meg_loopback_suppress_en), .fefi_tx_en(fefi_tx_en), .crs(crs), .rx_dv(rx_dv),
    .rxd(rxd), .sleep_mode(sleep_mode));

  pcs_mgmt_model i_pcs_mgmt_model (
    .clk_sys(clk_sys), .mdio_wire(mdio_wire), .mdc(mdc), .mdio_drv(m_drv), .mdio_en(m_en));

  // ----------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input logic [4:0] ra, output logic [15:0] d);
    i_pcs_mgmt_model.frame(pcs_pkg::OP_READ, 5'h03, ra, 16'h0000, d);
  endtask : rd

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] unused;
    i_pcs_mgmt_model.frame(pcs_pkg::OP_WRITE, 5'h03, ra, d, unused);
  endtask : wr

  task automatic close_out;
    $display("compared %0d, wrong %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  // values after reset
  task automatic t_reset;
    logic [15:0] d;
    rd(pcs_pkg::REG_CFG, d);
    check(d, 16'h0005);
    check({14'h0, fiber_mode, fefi_tx_en}, 16'h0003);
    rd(pcs_pkg::REG_STAT2, d);
    check(d, 16'h0000);
  endtask : t_reset

  task automatic t_cfg;
    logic [15:0] d;
    wr(pcs_pkg::REG_CFG, 16'hffff);
    rd(pcs_pkg::REG_CFG, d);
    check(d, 16'h01ff);
    check({12'h0, next_page_cap, fiber_mode, ten_meg_loopback_suppress_en, fefi_tx_en}, 16'h000d);
    // gate open but no page ability: capability must drop
    np_ability = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check({15'h0, next_page_cap}, 16'h0000);
    np_ability = 1'b1;
    wr(pcs_pkg::REG_CFG, 16'h0000);
    check({12'h0, next_page_cap, fiber_mode, ten_meg_loopback_suppress_en, fefi_tx_en}, 16'h0002);
    wr(pcs_pkg::REG_CFG, 16'h0100);
    check({15'h0, ten_meg_loopback_suppress_en}, 16'h0000);
    wr(pcs_pkg::REG_CFG, 16'h0000);
    full_duplex = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check({15'h0, ten_meg_loopback_suppress_en}, 16'h0000);
    full_duplex = 1'b0;
  endtask : t_cfg

  task automatic t_status;
    logic [15:0] d;
    for (int k = 0; k < 2; k++)
    begin
      {speed_100, tx_active, rx_active, col_active, link_up} = k ? 5'h0a : 5'h15;
      rd(pcs_pkg::REG_STAT2, d);
      check(d, k ? 16'h2800 : 16'h5400);
    end
    wr(pcs_pkg::REG_CFG, 16'h0001);
    {speed_100, tx_active, rx_active, col_active, link_up} = 5'h1f;
    wr(pcs_pkg::REG_STAT2, 16'hffff);
    rd(pcs_pkg::REG_STAT2, d);
    check(d, 16'h3c00);
    rd(5'h1f, d);
    check(d, 16'h0000);
    // another station address: the device stays silent
    i_pcs_mgmt_model.frame(pcs_pkg::OP_READ, 5'h04, pcs_pkg::REG_CFG, 16'h0000, d);
    check(d, 16'hffff);
    {speed_100, tx_active, rx_active, col_active} = 4'h0;
  endtask : t_status

  // one received frame: 3 preamble, delimiter, 2 data
  task automatic t_rx(input logic [15:0] cfg, input logic spd, input int dv_n,
                      input int crs_n, input logic [3:0] first);
    int ndv;
    int ncrs;
    logic [3:0] f;
    wr(pcs_pkg::REG_CFG, cfg);
    speed_100 = spd;
    ndv = 0;
    ncrs = 0;
    f = 4'h0;
    for (int c = 0; c < 12; c++)
    begin
      line_rx_valid = c < 6;
      crs_line = c < 4;
      line_sfd = c == 3;
      line_rxd = (c == 3) ? 4'hd : ((c < 3) ? 4'h5 : 4'ha);
      @(posedge clk_sys);
      #1;
      if (rx_dv === 1'b1 && ndv == 0)
        f = rxd;
      ndv += int'(rx_dv === 1'b1);
      ncrs += int'(crs === 1'b1);
    end
    check(16'(ndv), 16'(dv_n));
    check(16'(ncrs), 16'(crs_n));
    check({12'h0, f}, {12'h0, first});
    speed_100 = 1'b0;
  endtask : t_rx

  // timeout codes, code 11 and disabled never sleep
  task automatic t_sleep;
    int n;
    // timeout plus one output register stage; code 11 and disabled run out at 80
    int tm [5] = '{41, 21, 11, 80, 80};
    for (int k = 0; k < 5; k++)
    begin
      link_up = 1'b1;
      wr(pcs_pkg::REG_CFG, (k < 4) ? (16'h0040 | 16'(k << 3)) : 16'h0000);
      link_up = 1'b0;
      n = 0;
      while (sleep_mode !== 1'b1 && n < 80)
      begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      check(16'(n), 16'(tm[k]));
    end
  endtask : t_sleep

  // ----------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    nrst = 1'b0;
    {strap_media, strap_sleep, speed_100, full_duplex, link_up, tx_active} = 6'h20;
    {rx_active, col_active, crs_line, line_rx_valid, line_sfd, np_ability} = 6'h01;
    line_rxd = 4'h0;
    repeat (4) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    t_reset();
    t_cfg();
    t_status();
    t_rx(16'h0000, 1'b0, 3, 4, 4'hd);
    t_rx(16'h00a0, 1'b0, 6, 6, 4'h5);
    t_rx(16'h0080, 1'b0, 3, 6, 4'hd);
    t_rx(16'h0080, 1'b1, 6, 4, 4'h5);
    t_sleep();
    close_out();
  end

  // about 25 frames of 520 cycles are expected
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    $display("watchdog expired at %0t", $time);
    close_out();
  end
endmodule : test_pcs_regs
`default_nettype wire
